// file: logic/mop_map.svh
`ifndef MOP_MAP_SVH
`define MOP_MAP_SVH
// Summary of operation
// - Position store has 2000 entries, indices 0-1999
// - Bank of 32 index registers 0-31
// - Registers cleared only at reset or restart
// - Register loads above 1999 raise an error
// - Position entries limited to +/-39,999,999
// - Parenthesised register addresses the position store
// - Bare register reads or writes its content
// - Register bank and store shared by tasks
// - Programs 0-499 main, 500-999 subroutines
// - At most 100 programs stored in total
// - Main first block selects reference, absolute, pass modes
// - Main first block reloads accel times, origin
// - Stop mode waits for positioning completion
// - Pass mode chains moves without stopping
// - In-position-off mode skips positioning wait
// - Incremental targets relative, absolute targets absolute
// - No-error flag suppresses missing interrupt error
`define MOP_POS_DEPTH 2000
`define MOP_REG_COUNT 32
`define MOP_ADDR_W    11
`define MOP_ADDR_LAST 11'h7cf
`define MOP_REG_MAX   32'sh000007cf
`define MOP_POS_MAX   32'sh026259ff
`define MOP_MAIN_LAST 10'h1f3
`define MOP_SUB_LAST  10'h3e7
`define MOP_PROG_MAX  7'h64
`define MOP_TIME_W    16
`endif

// file: logic/mop_pkg.sv
package mop_pkg;
  typedef enum logic [1:0] {MOP_SRC_IMM, MOP_SRC_REG, MOP_SRC_IND, MOP_SRC_POS} mop_src_e;
  typedef enum logic {MOP_CRD_REF, MOP_CRD_WORK} mop_coord_e;
  typedef enum logic {MOP_CMD_ABS, MOP_CMD_INC} mop_cmd_e;
  typedef enum logic [1:0] {MOP_OPM_STOP, MOP_OPM_PASS, MOP_OPM_NOCHK} mop_opm_e;
  typedef enum logic [1:0] {MOP_PRG_MAIN, MOP_PRG_SUB, MOP_PRG_BAD} mop_prog_e;
  typedef enum logic {MOP_ST_IDLE, MOP_ST_RAM} mop_st_e;
  typedef logic signed [31:0] mop_val_t;
endpackage

// file: logic/mop_index_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "mop_map.svh"
module mop_index_bank
  import mop_pkg::*;
#(
  parameter int COUNT = `MOP_REG_COUNT,
  parameter int SW    = $clog2(COUNT),
  parameter int AW    = `MOP_ADDR_W
)(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          restart,
  input  wire logic          wr_en,
  input  wire logic [SW-1:0] wr_sel,
  input  wire mop_val_t      wr_data,
  input  wire logic [SW-1:0] rd_sel_a,
  input  wire logic [SW-1:0] rd_sel_b,
  output logic [AW-1:0]      rd_data_a,
  output logic [AW-1:0]      rd_data_b,
  output logic               wr_ack_r,
  output logic               wr_err_r
);
  logic [AW-1:0] bank_r [COUNT];
  logic          load_bad;
  logic [AW-1:0] sel_val;

  // Negative loads are refused too, they cannot be an address
  assign load_bad  = (wr_data < 0) || (wr_data > `MOP_REG_MAX);
  assign rd_data_a = bank_r[rd_sel_a];
  assign rd_data_b = bank_r[rd_sel_b];
  assign sel_val   = bank_r[wr_sel];

  // Contents persist across programs; only reset or restart clears
  always_ff @(posedge mclk)
  begin
    if (rst || restart)
    begin
      for (int i = 0; i < COUNT; i++)
        bank_r[i] <= '0;
    end
    else if (wr_en && !load_bad)
      bank_r[wr_sel] <= wr_data[AW-1:0];
  end

  // Load acknowledge and error, register left untouched on error
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ack_r <= 1'b0;
      wr_err_r <= 1'b0;
    end
    else
    begin
      wr_ack_r <= wr_en;
      wr_err_r <= wr_en && load_bad;
    end
  end

  load_reject_a: assert property (@(posedge mclk) disable iff (rst || restart)
    wr_en && load_bad |=> wr_err_r && (wr_sel != $past(wr_sel) || $stable(sel_val)))
    else $error("refused load changed a register");
  restart_clear_a: assert property (@(posedge mclk) disable iff (rst)
    restart |=> rd_data_a == '0 && rd_data_b == '0)
    else $error("register not zero after restart");
endmodule
`default_nettype wire

// file: logic/mop_pos_store.sv
`timescale 1ns/10ps
`default_nettype none
`include "mop_map.svh"
module mop_pos_store
  import mop_pkg::*;
#(
  parameter int AW = `MOP_ADDR_W,
  parameter int DEPTH = `MOP_POS_DEPTH
)(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire mop_val_t      wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output mop_val_t           rd_data_r,
  output logic               wr_err_r
);
  mop_val_t mem [DEPTH];
  logic     wr_bad;

  // Out-of-range value or address is refused, entry kept
  assign wr_bad = (wr_data > `MOP_POS_MAX) || (wr_data < -`MOP_POS_MAX)
                  || (wr_addr > `MOP_ADDR_LAST);

  // Storage array has no reset, like a real RAM
  always_ff @(posedge mclk)
  begin
    if (wr_en && !wr_bad)
      mem[wr_addr] <= wr_data;
  end

  // Registered read port, one cycle latency
  always_ff @(posedge mclk)
  begin
    if (rst)
      rd_data_r <= '0;
    else if (rd_en)
      rd_data_r <= (rd_addr > `MOP_ADDR_LAST) ? '0 : mem[rd_addr];
  end

  // Write error pulse
  always_ff @(posedge mclk)
  begin
    if (rst)
      wr_err_r <= 1'b0;
    else
      wr_err_r <= wr_en && wr_bad;
  end

  write_read_a: assert property (@(posedge mclk) disable iff (rst)
    wr_en && !wr_bad ##1 rd_en && rd_addr == $past(wr_addr) && !wr_en |=> rd_data_r == $past(wr_data, 2))
    else $error("stored entry not read back");
  range_guard_a: assert property (@(posedge mclk) disable iff (rst)
    wr_en && (wr_data > `MOP_POS_MAX || wr_data < -`MOP_POS_MAX) |=> wr_err_r)
    else $error("out of range entry not flagged");
endmodule
`default_nettype wire

// file: logic/mop_operand_resolver.sv
`timescale 1ns/10ps
`default_nettype none
`include "mop_map.svh"
module mop_operand_resolver
  import mop_pkg::*;
#(
  parameter int REGS  = `MOP_REG_COUNT,
  parameter int AW    = `MOP_ADDR_W,
  parameter int TW    = `MOP_TIME_W,
  parameter int PROGS = `MOP_PROG_MAX
)(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          restart,
  input  wire logic          op_req,
  input  wire mop_src_e      op_src,
  input  wire logic [4:0]    op_reg,
  input  wire logic [AW-1:0] op_addr,
  input  wire mop_val_t      op_imm,
  input  wire logic          op_axis,
  input  wire mop_val_t      cur_pos,
  output logic               op_busy_r,
  output logic               op_done_r,
  output logic               op_err_r,
  output mop_val_t           op_value_r,
  input  wire logic          reg_wr,
  input  wire logic [4:0]    reg_wr_sel,
  input  wire mop_val_t      reg_wr_data,
  output logic               reg_wr_done_r,
  output logic               reg_wr_err_r,
  input  wire logic          pos_wr,
  input  wire logic          pos_wr_ind,
  input  wire logic [4:0]    pos_wr_reg,
  input  wire logic [AW-1:0] pos_wr_addr,
  input  wire mop_val_t      pos_wr_data,
  output logic               pos_wr_err_r,
  input  wire logic          prog_load,
  input  wire logic [9:0]    prog_load_num,
  output logic               prog_load_err_r,
  output logic [6:0]         prog_count_r,
  input  wire logic          prog_start,
  input  wire logic [9:0]    prog_num,
  input  wire logic          prog_first,
  output logic               prog_main_r,
  output logic               prog_sub_r,
  output logic               prog_num_err_r,
  input  wire logic          coord_set,
  input  wire mop_coord_e    coord_new,
  input  wire logic          cmd_set,
  input  wire mop_cmd_e      cmd_new,
  input  wire logic          opm_set,
  input  wire mop_opm_e      opm_new,
  output mop_coord_e         coord_r,
  output mop_cmd_e           cmd_r,
  output mop_opm_e           opm_r,
  input  wire logic [TW-1:0] sys_acc,
  input  wire logic [TW-1:0] sys_iacc,
  input  wire mop_val_t      sys_origin,
  input  wire logic          acc_set,
  input  wire logic [TW-1:0] acc_new,
  input  wire logic [TW-1:0] iacc_new,
  input  wire logic          origin_set,
  input  wire mop_val_t      origin_new,
  output logic [TW-1:0]      acc_r,
  output logic [TW-1:0]      iacc_r,
  output mop_val_t           origin_r,
  input  wire logic          move_done,
  input  wire logic          in_pos,
  output logic               next_ok_r,
  output logic               blend_r,
  input  wire logic          feed_arm,
  input  wire logic          feed_noerr,
  input  wire logic          feed_trig,
  input  wire logic          feed_end,
  output logic               feed_hit_r,
  output logic               feed_err_r
);
  mop_st_e       st_r;
  logic [AW-1:0] reg_a;
  logic [AW-1:0] reg_b;
  mop_val_t      ram_q;
  logic          ram_rd;
  logic [AW-1:0] ram_addr;
  logic          pos_addr_ok;
  logic          take;
  mop_prog_e     start_cls;
  mop_prog_e     load_cls;
  logic          main_first;
  logic          feed_arm_r;
  logic          feed_noerr_r;
  logic          axis_r;
  // Axis targets in incremental mode add the current position
  function automatic mop_val_t resolve(mop_val_t v, mop_val_t cur, logic axis, mop_cmd_e cmd);
    resolve = (axis && cmd == MOP_CMD_INC) ? v + cur : v;
  endfunction
  // Program number classes; anything past the subroutine range is refused
  function automatic mop_prog_e prog_class(logic [9:0] num);
    prog_class = (num <= `MOP_MAIN_LAST) ? MOP_PRG_MAIN : (num <= `MOP_SUB_LAST) ? MOP_PRG_SUB : MOP_PRG_BAD;
  endfunction
  // One bank and one store for every task, no per-task copies
  mop_index_bank #(
    .COUNT (REGS),
    .AW    (AW)
  ) u_bank (
    .mclk      (mclk),
    .rst       (rst),
    .restart   (restart),
    .wr_en     (reg_wr),
    .wr_sel    (reg_wr_sel),
    .wr_data   (reg_wr_data),
    .rd_sel_a  (op_reg),
    .rd_sel_b  (pos_wr_reg),
    .rd_data_a (reg_a),
    .rd_data_b (reg_b),
    .wr_ack_r  (reg_wr_done_r),
    .wr_err_r  (reg_wr_err_r)
  );
  mop_pos_store #(
    .AW (AW)
  ) u_store (
    .mclk      (mclk),
    .rst       (rst),
    .wr_en     (pos_wr),
    .wr_addr   (pos_wr_ind ? reg_b : pos_wr_addr),
    .wr_data   (pos_wr_data),
    .rd_en     (ram_rd),
    .rd_addr   (ram_addr),
    .rd_data_r (ram_q),
    .wr_err_r  (pos_wr_err_r)
  );
  // Store read launch for indirect and direct position operands
  assign take        = op_req && st_r == MOP_ST_IDLE;
  assign pos_addr_ok = op_addr <= `MOP_ADDR_LAST;
  assign ram_rd      = take && (op_src == MOP_SRC_IND || (op_src == MOP_SRC_POS && pos_addr_ok));
  assign ram_addr    = (op_src == MOP_SRC_IND) ? reg_a : op_addr;
  // Requests while busy are ignored; the executor waits for done
  always_ff @(posedge mclk)
  begin
    if (rst)
      st_r <= MOP_ST_IDLE;
    else
      unique case (st_r)
        MOP_ST_IDLE: st_r <= ram_rd ? MOP_ST_RAM : MOP_ST_IDLE;
        MOP_ST_RAM:  st_r <= MOP_ST_IDLE;
      endcase
  end
  // Operand answer registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      op_done_r  <= 1'b0;
      op_err_r   <= 1'b0;
      op_busy_r  <= 1'b0;
      op_value_r <= '0;
      axis_r     <= 1'b0;
    end
    else
    begin
      op_done_r <= 1'b0;
      op_err_r  <= 1'b0;
      op_busy_r <= ram_rd;
      if (ram_rd)
        axis_r <= op_axis;
      if (st_r == MOP_ST_RAM)
      begin
        op_done_r  <= 1'b1;
        op_value_r <= resolve(ram_q, cur_pos, axis_r, cmd_r);
      end
      else if (take)
      begin
        unique case (op_src)
          MOP_SRC_IMM:
          begin
            op_done_r  <= 1'b1;
            op_value_r <= resolve(op_imm, cur_pos, op_axis, cmd_r);
          end
          MOP_SRC_REG:
          begin
            op_done_r  <= 1'b1;
            op_value_r <= 32'(reg_a);
          end
          MOP_SRC_IND: op_done_r <= 1'b0;
          MOP_SRC_POS:
          begin
            op_done_r <= !pos_addr_ok;
            op_err_r  <= !pos_addr_ok;
          end
        endcase
      end
    end
  end
  // Program directory count; entries never leave short of reset
  assign load_cls = prog_class(prog_load_num);
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prog_count_r    <= '0;
      prog_load_err_r <= 1'b0;
    end
    else
    begin
      prog_load_err_r <= 1'b0;
      if (prog_load)
      begin
        if (load_cls == MOP_PRG_BAD || prog_count_r >= 7'(PROGS))
          prog_load_err_r <= 1'b1;
        else
          prog_count_r <= prog_count_r + 7'h01;
      end
    end
  end
  // Program start classification
  assign start_cls  = prog_class(prog_num);
  assign main_first = prog_start && prog_first && start_cls == MOP_PRG_MAIN;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prog_main_r    <= 1'b0;
      prog_sub_r     <= 1'b0;
      prog_num_err_r <= 1'b0;
    end
    else if (prog_start)
    begin
      prog_main_r    <= start_cls == MOP_PRG_MAIN;
      prog_sub_r     <= start_cls == MOP_PRG_SUB;
      prog_num_err_r <= start_cls == MOP_PRG_BAD;
    end
    else
      prog_num_err_r <= 1'b0;
  end
  // Modes; a main start from block zero wins over a same-cycle set
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      coord_r <= MOP_CRD_REF;
      cmd_r   <= MOP_CMD_ABS;
      opm_r   <= MOP_OPM_PASS;
    end
    else if (main_first)
    begin
      coord_r <= MOP_CRD_REF;
      cmd_r   <= MOP_CMD_ABS;
      opm_r   <= MOP_OPM_PASS;
    end
    else
    begin
      if (coord_set)
        coord_r <= coord_new;
      if (cmd_set)
        cmd_r <= cmd_new;
      if (opm_set)
        opm_r <= opm_new;
    end
  end
  // Working timing and offset copies, reloaded at a main start from the first block
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_r    <= '0;
      iacc_r   <= '0;
      origin_r <= '0;
    end
    else if (main_first)
    begin
      acc_r    <= sys_acc;
      iacc_r   <= sys_iacc;
      origin_r <= sys_origin;
    end
    else
    begin
      if (acc_set)
      begin
        acc_r  <= acc_new;
        iacc_r <= iacc_new;
      end
      if (origin_set)
        origin_r <= origin_new;
    end
  end
  // Release of the next interpolation move per operating mode
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      next_ok_r <= 1'b0;
      blend_r   <= 1'b0;
    end
    else
    begin
      blend_r <= opm_r == MOP_OPM_PASS;
      unique case (opm_r)
        MOP_OPM_STOP:                next_ok_r <= in_pos;
        MOP_OPM_PASS, MOP_OPM_NOCHK: next_ok_r <= move_done || in_pos;
        default:                     next_ok_r <= in_pos;
      endcase
    end
  end
  // Interrupt feeding: trigger seen in the end cycle still counts
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      feed_arm_r   <= 1'b0;
      feed_noerr_r <= 1'b0;
      feed_hit_r   <= 1'b0;
      feed_err_r   <= 1'b0;
    end
    else
    begin
      feed_err_r <= 1'b0;
      if (feed_arm)
      begin
        feed_arm_r   <= 1'b1;
        feed_noerr_r <= feed_noerr;
        feed_hit_r   <= feed_trig;
      end
      else if (feed_arm_r)
      begin
        if (feed_trig)
          feed_hit_r <= 1'b1;
        if (feed_end)
        begin
          feed_arm_r <= 1'b0;
          feed_err_r <= !feed_hit_r && !feed_trig && !feed_noerr_r;
        end
      end
    end
  end
  main_defaults_a: assert property (@(posedge mclk) disable iff (rst)
    main_first |=> coord_r == MOP_CRD_REF && cmd_r == MOP_CMD_ABS && opm_r == MOP_OPM_PASS)
    else $error("main start defaults not applied");
  param_reload_a: assert property (@(posedge mclk) disable iff (rst)
    main_first |=> acc_r == $past(sys_acc) && iacc_r == $past(sys_iacc) && origin_r == $past(sys_origin))
    else $error("system parameters not reloaded");
  stop_wait_a: assert property (@(posedge mclk) disable iff (rst)
    opm_r == MOP_OPM_STOP && !in_pos |=> !next_ok_r)
    else $error("stop mode released before positioning");
  pass_chain_a: assert property (@(posedge mclk) disable iff (rst)
    opm_r == MOP_OPM_PASS && move_done |=> next_ok_r && blend_r)
    else $error("pass mode did not chain");
  nochk_go_a: assert property (@(posedge mclk) disable iff (rst)
    opm_r == MOP_OPM_NOCHK && move_done && !in_pos |=> next_ok_r && !blend_r)
    else $error("check-off mode waited for positioning");
  prog_class_a: assert property (@(posedge mclk) disable iff (rst)
    prog_start && prog_num > `MOP_MAIN_LAST && prog_num <= `MOP_SUB_LAST |=> prog_sub_r && !prog_main_r)
    else $error("subroutine number misclassified");
  prog_limit_a: assert property (@(posedge mclk) disable iff (rst)
    prog_load && prog_count_r == 7'(PROGS) |=> prog_load_err_r && $stable(prog_count_r))
    else $error("program count passed its limit");
  indirect_time_a: assert property (@(posedge mclk) disable iff (rst)
    take && op_src == MOP_SRC_IND |=> !op_done_r ##1 op_done_r && !op_err_r)
    else $error("indirect operand timing wrong");
  direct_read_a: assert property (@(posedge mclk) disable iff (rst)
    take && op_src == MOP_SRC_REG |=> op_done_r && op_value_r == 32'($past(reg_a)))
    else $error("direct register value wrong");
  incr_target_a: assert property (@(posedge mclk) disable iff (rst)
    take && op_src == MOP_SRC_IMM && op_axis && cmd_r == MOP_CMD_INC
    |=> op_value_r == $past(op_imm) + $past(cur_pos))
    else $error("incremental target not relative");
  feed_quiet_a: assert property (@(posedge mclk) disable iff (rst)
    feed_arm && feed_noerr ##1 (!feed_arm && !feed_trig)[*2] |=> !feed_err_r)
    else $error("missing interrupt flagged despite no-error");
endmodule
`default_nettype wire

// file: test/mop_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module mop_seq_model #(
  parameter int FAST   = 2,
  parameter int SLOW   = 6,
  parameter int SETTLE = 3
)(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic slow,
  output logic      move_done,
  output logic      in_pos
);
  logic [7:0] cnt_r;
  logic [7:0] lat_r;

  // Move timer; saturates so an idle axis reads as finished and settled
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_r <= 8'hff;
      lat_r <= 8'(FAST);
    end
    else if (go)
    begin
      cnt_r <= 8'h00;
      lat_r <= slow ? 8'(SLOW) : 8'(FAST);
    end
    else if (cnt_r != 8'hff)
      cnt_r <= cnt_r + 8'h01;
  end

  // Command output ends first, settling lags so the two can be told apart
  assign move_done = (cnt_r >= lat_r);
  assign in_pos    = (cnt_r >= lat_r + 8'(SETTLE));
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mop_map.svh"
module tb_top
  import mop_pkg::*;
;
  logic        mclk, rst, restart, op_req, op_axis, op_busy_r, op_done_r, op_err_r;
  mop_src_e    op_src;
  logic [4:0]  op_reg, reg_wr_sel, pos_wr_reg;
  logic [10:0] op_addr, pos_wr_addr;
  mop_val_t    op_imm, cur_pos, op_value_r, reg_wr_data, pos_wr_data, v;
  logic        reg_wr, reg_wr_done_r, reg_wr_err_r, pos_wr, pos_wr_ind, pos_wr_err_r, e;
  logic        prog_load, prog_load_err_r, prog_start, prog_first, prog_main_r, prog_sub_r, prog_num_err_r;
  logic [9:0]  prog_load_num, prog_num;
  logic [6:0]  prog_count_r;
  logic        coord_set, cmd_set, opm_set, acc_set, origin_set;
  mop_coord_e  coord_new, coord_r;
  mop_cmd_e    cmd_new, cmd_r;
  mop_opm_e    opm_new, opm_r;
  logic [15:0] sys_acc, sys_iacc, acc_new, iacc_new, acc_r, iacc_r;
  mop_val_t    sys_origin, origin_new, origin_r;
  logic        move_done, in_pos, next_ok_r, blend_r, go, slow;
  logic        feed_arm, feed_noerr, feed_trig, feed_end, feed_hit_r, feed_err_r;
  int          error_cnt, checked, n;
  logic [9:0]  pnum [5] = '{10'h000, 10'h1f3, 10'h1f4, 10'h3e7, 10'h3e8};
  mop_opm_e    modes [3] = '{MOP_OPM_STOP, MOP_OPM_PASS, MOP_OPM_NOCHK};

  mop_operand_resolver u_mop_operand_resolver (.*);

  mop_seq_model u_mop_seq_model (
    .mclk      (mclk),
    .rst       (rst),
    .go        (go),
    .slow      (slow),
    .move_done (move_done),
    .in_pos    (in_pos)
  );

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Compare and tally; case equality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Counts: checked %0d, error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Operand request; waits a bounded time for the answer pulse
  task automatic rd(input mop_src_e s, input logic [4:0] r, input logic [10:0] a, input mop_val_t im,
                    input logic ax);
    @(posedge mclk);
    op_req <= 1'b1;
    op_src <= s;
    op_reg <= r;
    op_addr <= a;
    op_imm <= im;
    op_axis <= ax;
    @(posedge mclk);
    op_req <= 1'b0;
    n = 0;
    #1;
    chk(op_busy_r, s == MOP_SRC_IND || (s == MOP_SRC_POS && a <= `MOP_ADDR_LAST));
    while (op_done_r !== 1'b1 && n < 6)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(op_done_r, 1'b1);
    v = op_value_r;
    e = op_err_r;
  endtask

  // Index register write; answer comes one cycle later
  task automatic wreg(input logic [4:0] s, input mop_val_t d, input logic xe);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_wr_sel <= s;
    reg_wr_data <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
    chk(reg_wr_done_r, 1'b1);
    chk(reg_wr_err_r, xe);
  endtask

  // Position store write, direct or through a register
  task automatic wpos(input logic ind, input logic [4:0] r, input logic [10:0] a, input mop_val_t d,
                      input logic xe);
    @(posedge mclk);
    pos_wr <= 1'b1;
    pos_wr_ind <= ind;
    pos_wr_reg <= r;
    pos_wr_addr <= a;
    pos_wr_data <= d;
    @(posedge mclk);
    pos_wr <= 1'b0;
    #1;
    chk(pos_wr_err_r, xe);
  endtask

  // Program load or start pulse
  task automatic prog(input logic ld, input logic [9:0] num, input logic first);
    @(posedge mclk);
    prog_load <= ld;
    prog_start <= !ld;
    prog_load_num <= num;
    prog_num <= num;
    prog_first <= first;
    @(posedge mclk);
    prog_load <= 1'b0;
    prog_start <= 1'b0;
    #1;
  endtask

  // Generous ceiling; the sequence needs well under 2000 cycles
  initial
  begin
    #100000;
    error_cnt++;
    $display("Watchdog expired");
    end_of_test();
  end

  // Main sequence
  initial
  begin
    {restart, op_req, op_axis, reg_wr, pos_wr, pos_wr_ind, prog_load, prog_start, prog_first} = '0;
    {coord_set, cmd_set, opm_set, acc_set, origin_set, feed_arm, feed_noerr, feed_trig, feed_end} = '0;
    {op_reg, op_addr, op_imm, reg_wr_sel, reg_wr_data, pos_wr_reg, pos_wr_addr, pos_wr_data} = '0;
    {prog_load_num, prog_num, go, slow} = '0;
    op_src = MOP_SRC_IMM;
    coord_new = MOP_CRD_WORK;
    cmd_new = MOP_CMD_INC;
    opm_new = MOP_OPM_STOP;
    cur_pos = 32'sh00000064;
    {sys_acc, sys_iacc, sys_origin} = {16'h0123, 16'h0456, 32'sh00000789};
    {acc_new, iacc_new, origin_new} = {16'h0aaa, 16'h0bbb, 32'sh00000ccc};
    error_cnt = 0;
    checked = 0;
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;

    rd(MOP_SRC_REG, 5'h1f, 11'h000, 32'sh0, 1'b0);
    chk(v, 32'h0);
    wreg(5'h00, `MOP_REG_MAX, 1'b0);
    wreg(5'h1f, 32'sh00000005, 1'b0);
    wreg(5'h1f, `MOP_REG_MAX + 32'sh1, 1'b1);
    rd(MOP_SRC_REG, 5'h1f, 11'h000, 32'sh0, 1'b0);
    chk(v, 32'h5);
    rd(MOP_SRC_REG, 5'h00, 11'h000, 32'sh0, 1'b0);
    chk(v, `MOP_REG_MAX);
    $display("Test registers done");

    wpos(1'b0, 5'h00, `MOP_ADDR_LAST, `MOP_POS_MAX, 1'b0);
    wpos(1'b0, 5'h00, 11'h000, -`MOP_POS_MAX, 1'b0);
    wpos(1'b1, 5'h1f, 11'h000, 32'sh0000004d, 1'b0);
    wpos(1'b0, 5'h00, 11'h005, `MOP_POS_MAX + 32'sh1, 1'b1);
    wpos(1'b0, 5'h00, 11'h7d0, 32'sh1, 1'b1);
    rd(MOP_SRC_IND, 5'h00, 11'h000, 32'sh0, 1'b0);
    chk(v, `MOP_POS_MAX);
    rd(MOP_SRC_POS, 5'h00, 11'h000, 32'sh0, 1'b0);
    chk(v, -`MOP_POS_MAX);
    rd(MOP_SRC_POS, 5'h00, 11'h005, 32'sh0, 1'b0);
    chk(v, 32'h4d);
    rd(MOP_SRC_POS, 5'h00, 11'h7d0, 32'sh0, 1'b0);
    chk(e, 1'b1);
    chk(v, 32'h4d);
    // Read in the cycle after a write must already see the new entry
    @(posedge mclk);
    {pos_wr, pos_wr_ind, pos_wr_addr, pos_wr_data} <= {2'b10, 11'h010, 32'sh00000123};
    fork
      rd(MOP_SRC_POS, 5'h00, 11'h010, 32'sh0, 1'b0);
      @(posedge mclk) pos_wr <= 1'b0;
    join
    chk(v, 32'h123);
    $display("Test store done");

    rd(MOP_SRC_IMM, 5'h00, 11'h000, 32'sh5, 1'b1);
    chk(v, 32'h5);
    @(posedge mclk);
    cmd_set <= 1'b1;
    @(posedge mclk);
    cmd_set <= 1'b0;
    rd(MOP_SRC_IMM, 5'h00, 11'h000, 32'sh5, 1'b1);
    chk(v, 32'h69);
    rd(MOP_SRC_IND, 5'h00, 11'h000, 32'sh0, 1'b1);
    chk(v, `MOP_POS_MAX + 32'sh64);
    $display("Test command mode done");

    @(posedge mclk);
    {coord_set, opm_set, acc_set, origin_set} <= 4'hf;
    @(posedge mclk);
    {coord_set, opm_set, acc_set, origin_set} <= 4'h0;
    #1;
    chk(acc_r, acc_new);
    chk({coord_r, cmd_r, opm_r}, {MOP_CRD_WORK, MOP_CMD_INC, MOP_OPM_STOP});
    prog(1'b0, 10'h064, 1'b1);
    chk({coord_r, cmd_r, opm_r}, {MOP_CRD_REF, MOP_CMD_ABS, MOP_OPM_PASS});
    chk({acc_r, iacc_r}, {sys_acc, sys_iacc});
    chk(origin_r, sys_origin);
    // Starts only; closing each run with its own end command is the executor's part
    for (int i = 0; i < 5; i++)
    begin
      prog(1'b0, pnum[i], 1'b0);
      chk(prog_num_err_r, i == 4);
      if (i < 4)
        chk({prog_main_r, prog_sub_r}, (i < 2) ? 2'b10 : 2'b01);
    end
    rd(MOP_SRC_REG, 5'h00, 11'h000, 32'sh0, 1'b0);
    chk(v, `MOP_REG_MAX);
    @(posedge mclk);
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
    rd(MOP_SRC_REG, 5'h00, 11'h000, 32'sh0, 1'b0);
    chk(v, 32'h0);
    $display("Test program start done");

    prog(1'b1, 10'h3e8, 1'b0);
    chk({prog_load_err_r, prog_count_r}, 8'h80);
    for (int i = 0; i < 100; i++)
    begin
      prog(1'b1, 10'(i * 7), 1'b0);
      chk(prog_load_err_r, 1'b0);
    end
    prog(1'b1, 10'h3e7, 1'b0);
    chk({prog_load_err_r, prog_count_r}, {1'b1, `MOP_PROG_MAX});
    $display("Test program count done");

    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      opm_set <= 1'b1;
      opm_new <= modes[i];
      go <= 1'b1;
      slow <= (i == 1);
      @(posedge mclk);
      opm_set <= 1'b0;
      go <= 1'b0;
      n = 0;
      #1;
      while (move_done !== 1'b1 && n < 20)
      begin
        @(posedge mclk);
        #1;
        n++;
      end
      @(posedge mclk);
      #1;
      chk(next_ok_r, i != 0);
      while (in_pos !== 1'b1 && n < 40)
      begin
        @(posedge mclk);
        #1;
        n++;
      end
      @(posedge mclk);
      #1;
      chk({next_ok_r, blend_r}, {1'b1, i == 1});
    end
    $display("Test operating mode done");

    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      feed_arm <= 1'b1;
      feed_noerr <= (i == 1);
      @(posedge mclk);
      feed_arm <= 1'b0;
      feed_trig <= (i == 2);
      @(posedge mclk);
      feed_trig <= 1'b0;
      feed_end <= 1'b1;
      @(posedge mclk);
      feed_end <= 1'b0;
      #1;
      chk({feed_err_r, feed_hit_r}, {i == 0, i == 2});
    end
    $display("Test interrupt feeding done");
    end_of_test();
  end
endmodule
`default_nettype wire
